// >>> bench/cfs_far_side_model.sv
`timescale 1ns/1ps
// four mosfet drivers and a system monitor on the far side of the pins
module cfs_far_side_model (
  input wire logic [3:0] pwmDrive,
  input wire logic [3:0] pwmOeN,
  input wire logic outputInWindowFlagOut,
  input wire logic outputInWindowFlagOeN,
  input wire logic crowbarGateDrive,
  output logic pgLine,
  output logic [3:0] lowerOn,
  output logic [3:0] upperOn,
  output logic inputCrowbarOn
);
  // open-drain wire with a pull-up, so a released pin reads high
  assign pgLine = outputInWindowFlagOeN ? 1'b1 : outputInWindowFlagOut;
  // floating pwm turns both switches off, driven low clamps via the lower one
  assign lowerOn = ~pwmOeN & ~pwmDrive;
  assign upperOn = ~pwmOeN & pwmDrive;
  // input-rail switch follows the gate drive
  assign inputCrowbarOn = crowbarGateDrive;
endmodule : cfs_far_side_model

// >>> bench/cfs_fault_supervisor_tb.sv
`timescale 1ns/1ps
`include "cfs_params.svh"
module cfs_fault_supervisor_tb
  import cfs_pkg::*;
  ;
  typedef struct {logic [11:0] sensed; logic [7:0] cur; logic [3:0] pwmIn; logic pg;} cfs_row_s;
  logic ref_clk = 1'b0;
  logic nrst, supplyOk, enableAbove, freqSelectShutdownInput;
  logic [4:0] voltageCodeInput;
  logic [11:0] sensedOutputDifference;
  logic [7:0] meanChannelCurrent, wbAdr;
  logic [3:0] pwmModulated, pwmDrive, pwmOeN, lowerOn, upperOn;
  logic pgOut, pgOeN, pgLine, crowbarGateDrive, inputCrowbarOn, phaseTick;
  logic wbCyc, wbStb, wbWe, wbAck;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rd;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n, t0;
  // run state rows: code 0 puts the reference at its top value
  cfs_row_s rows [5] = '{'{12'h4b0, 8'h00, 4'ha, 1'b1}, '{12'h4af, 8'h00, 4'h5, 1'b0},
    '{12'h000, 8'h5a, 4'h3, 1'b0}, '{12'h5dc, 8'h5a, 4'hc, 1'b1}, '{12'h897, 8'h00, 4'hf, 1'b1}};

  always #10 ref_clk = ~ref_clk;

  cfs_fault_supervisor dut (.ref_clk(ref_clk), .nrst(nrst), .supplyOk(supplyOk),
    .enableAbove(enableAbove), .freqSelectShutdownInput(freqSelectShutdownInput),
    .voltageCodeInput(voltageCodeInput), .sensedOutputDifference(sensedOutputDifference),
    .meanChannelCurrent(meanChannelCurrent), .pwmModulated(pwmModulated),
    .pwmDrive(pwmDrive), .pwmOeN(pwmOeN), .outputInWindowFlagIn(pgLine),
    .outputInWindowFlagOut(pgOut), .outputInWindowFlagOeN(pgOeN),
    .crowbarGateDrive(crowbarGateDrive), .phaseTick(phaseTick), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck));

  cfs_far_side_model partner (.pwmDrive(pwmDrive), .pwmOeN(pwmOeN),
    .outputInWindowFlagOut(pgOut), .outputInWindowFlagOeN(pgOeN),
    .crowbarGateDrive(crowbarGateDrive), .pgLine(pgLine), .lowerOn(lowerOn),
    .upperOn(upperOn), .inputCrowbarOn(inputCrowbarOn));

  // ceiling well above the longest path through the hiccup tests
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      $display("unexpected at %0t: run too long", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("counts: %0d compared, %0d unexpected", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // checks land at the falling edge, where registered outputs have settled
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick

  // classic single cycle; released at the edge that sees ack high, or after 20 more edges without it
  task automatic wb(input logic [7:0] adr, input logic we, input logic [31:0] d);
    int lim;
    lim = 0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatW <= d;
    @(posedge ref_clk);
    // ack is looked at on rising edges only, before the slave updates it
    while (wbAck !== 1'b1 && lim < 20) begin
      @(posedge ref_clk);
      lim++;
    end
    if (lim == 20) chk(32'h0, 32'h1, "no ack");
    rd = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb

  task automatic rd_status();
    wb(`CFS_REG_STATUS, 1'b0, 32'h0);
  endtask : rd_status

  // polls the state field a bounded number of times
  task automatic poll(input cfs_state_e st, input int lim);
    int k;
    k = 0;
    rd_status();
    while (rd[1:0] !== st && k < lim) begin
      rd_status();
      k++;
    end
    chk(32'(rd[1:0]), 32'(st), "state");
  endtask : poll

  initial begin
    nrst = 1'b0;
    supplyOk = 1'b1;
    enableAbove = 1'b0;
    freqSelectShutdownInput = 1'b1;
    voltageCodeInput = 5'h00;
    sensedOutputDifference = 12'h000;
    meanChannelCurrent = 8'h00;
    pwmModulated = 4'h0;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
    wbSel = 4'hf;
    tick(5);
    chk(32'({pwmOeN, pgLine, crowbarGateDrive}), 32'h3c, "reset pins");
    @(posedge ref_clk);
    nrst <= 1'b1;
    wb(`CFS_REG_CTRL, 1'b0, 32'h0);
    chk(rd, 32'(`CFS_DIV_RESET), "divider reset");
    // any window of 200 clocks holds a fixed number of ticks at the reset period
    n = 0;
    repeat (200) begin
      @(posedge ref_clk);
      n += int'(phaseTick);
    end
    chk(32'(n), 32'(200 / `CFS_DIV_RESET), "phase tick rate");
    // lane 1 masked off, so only the low byte of the period lands
    wbSel <= 4'h1;
    wb(`CFS_REG_CTRL, 1'b1, 32'h0201);
    wbSel <= 4'hf;
    wb(8'h0c, 1'b1, 32'hffff);
    wb(8'h0c, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped");
    wb(`CFS_REG_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1, "divider");
    $display("test registers done");
    // supply, frequency-select and no-load code each missing in turn keep the block in shutdown
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      enableAbove <= 1'b1;
      supplyOk <= (i != 0);
      freqSelectShutdownInput <= (i != 1);
      voltageCodeInput <= (i == 2) ? `CFS_CODE_NOLOAD : 5'h00;
      tick(20);
      chk(32'(pwmOeN), 32'hf, "held off");
      rd_status();
      chk(32'(rd[1:0]), 32'(CFS_OFF), "stays off");
    end
    @(posedge ref_clk);
    voltageCodeInput <= 5'h00;
    tick(6);
    chk(32'({pwmOeN, pgLine}), 32'h0, "soft start, below window");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h5dc;
    tick(4);
    chk(32'(pgLine), 32'h1, "pg in soft start");
    tick(1880);
    rd_status();
    chk(32'(rd[1:0]), 32'(CFS_SOFT), "still soft");
    poll(CFS_RUN, 100);
    $display("test startup done");
    foreach (rows[i]) begin
      @(posedge ref_clk);
      sensedOutputDifference <= rows[i].sensed;
      meanChannelCurrent <= rows[i].cur;
      pwmModulated <= rows[i].pwmIn;
      tick(5);
      chk(32'(pgLine), 32'(rows[i].pg), "window");
      chk(32'({pwmOeN, pwmDrive}), 32'(rows[i].pwmIn), "switching");
    end
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h5dc;
    meanChannelCurrent <= 8'h00;
    enableAbove <= 1'b0;
    tick(6);
    chk(32'(pgLine), 32'h1, "pg held on disable");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h3e8;
    tick(4);
    chk(32'(pgLine), 32'h0, "pg after decay");
    @(posedge ref_clk);
    enableAbove <= 1'b1;
    sensedOutputDifference <= 12'h5dc;
    poll(CFS_RUN, 800);
    $display("test window done");
    // one trip, then a clean retry
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h5b;
    tick(6);
    chk(32'({lowerOn, upperOn, pgLine}), 32'h0, "trip");
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h00;
    n = 0;
    while (pwmOeN !== 4'h0 && n < 3000) begin
      tick(1);
      n++;
    end
    chk(32'(n > 2030 && n < 2060), 32'h1, "hiccup wait");
    rd_status();
    chk(32'(rd[4:2]), 32'h1, "one retry");
    poll(CFS_RUN, 800);
    chk(32'({rd[4:2], pgLine}), 32'h1, "clean retry");
    // persistent overload: eight attempts then latch-off
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h5b;
    t0 = cycles;
    n = 0;
    rd_status();
    while (rd[6] !== 1'b1 && n < 6000) begin
      rd_status();
      n++;
    end
    chk(32'(cycles - t0 > 14300 && cycles - t0 < 14600), 32'h1, "latch time");
    chk(32'({pwmOeN, pgLine}), 32'h1e, "latched off");
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h00;
    freqSelectShutdownInput <= 1'b0;
    tick(4);
    @(posedge ref_clk);
    freqSelectShutdownInput <= 1'b1;
    tick(3000);
    rd_status();
    chk(32'({rd[6], pwmOeN}), 32'h1f, "still latched");
    @(posedge ref_clk);
    enableAbove <= 1'b0;
    tick(3);
    rd_status();
    chk(32'({rd[6], rd[4:2]}), 32'h0, "latch cleared");
    @(posedge ref_clk);
    enableAbove <= 1'b1;
    poll(CFS_RUN, 800);
    $display("test overcurrent done");
    // overload during a reference move must not trip
    @(posedge ref_clk);
    voltageCodeInput <= 5'h1e;
    tick(8);
    rd_status();
    chk(32'(rd[12]), 32'h1, "ref moving");
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h5b;
    tick(6);
    @(posedge ref_clk);
    meanChannelCurrent <= 8'h00;
    tick(4);
    rd_status();
    chk(32'({rd[12], rd[1:0]}), 32'({1'b1, CFS_RUN}), "blanked");
    tick(100);
    rd_status();
    chk(32'({rd[12], rd[20:16]}), 32'h1e, "code reached");
    @(posedge ref_clk);
    voltageCodeInput <= 5'h00;
    tick(100);
    $display("test blanking done");
    // overvoltage: clamp, release at reference, clamp again, latched
    @(posedge ref_clk);
    sensedOutputDifference <= `CFS_OV_MV;
    tick(4);
    chk(32'({pgLine, inputCrowbarOn}), 32'h1, "ov pins");
    tick(1);
    chk(32'(lowerOn), 32'hf, "clamp");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h640;
    tick(6);
    chk(32'(lowerOn), 32'hf, "clamp above ref");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h5dc;
    tick(6);
    chk(32'({lowerOn, upperOn}), 32'h0, "released");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h8fc;
    tick(6);
    chk(32'(lowerOn), 32'hf, "re-clamp");
    @(posedge ref_clk);
    sensedOutputDifference <= 12'h5dc;
    tick(50);
    chk(32'({lowerOn, upperOn, pgLine, inputCrowbarOn}), 32'h1, "ov latched");
    @(posedge ref_clk);
    enableAbove <= 1'b0;
    tick(2);
    chk(32'(crowbarGateDrive), 32'h0, "crowbar cleared");
    $display("test overvoltage done");
    close_out();
  end
endmodule : cfs_fault_supervisor_tb

// >>> rtl/cfs_fault_supervisor.sv
`timescale 1ns/1ps
`include "cfs_params.svh"
module cfs_fault_supervisor
  import cfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic supplyOk,
  input wire logic enableAbove,
  input wire logic freqSelectShutdownInput,
  input wire logic [4:0] voltageCodeInput,
  input wire logic [11:0] sensedOutputDifference,
  input wire logic [7:0] meanChannelCurrent,
  input wire logic [3:0] pwmModulated,
  output logic [3:0] pwmDrive,
  output logic [3:0] pwmOeN,
  input wire logic outputInWindowFlagIn,
  output logic outputInWindowFlagOut,
  output logic outputInWindowFlagOeN,
  output logic crowbarGateDrive,
  output logic phaseTick,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  cfs_state_e state_ff, nxtState;
  cfs_tick_t tickCnt_ff, nxtTickCnt;
  logic [15:0] divPeriod_ff, divCnt_ff, divLast;
  logic [2:0] retryCnt_ff;
  logic ovLatched_ff, ocLatched_ff, ovClamp_ff, pg_ff, nxtPg;
  cfs_code_t refCode_ff, targetCode_ff, codeSeen_ff;
  logic stepPhase_ff;
  logic [3:0] pwmDrive_ff, pwmOeN_ff;
  logic ack_ff;
  logic [31:0] datOut_ff;
  logic [31:0] statusWord;
  logic [11:0] refMv;
  logic [12:0] diffPlus;
  logic [3:0] cmpRaw, cmpSync;
  logic uvS, ovS, ocS, atRefS;
  logic porClear, runOk, refMoving, ocTrip, active, tickWrap, codeStable;
  logic forceLow, switching, retryFull;
  logic wbReq, wbWrite, selCtrl, selStatus, selCount;

  // reference in mV: top value minus one step per code
  function automatic logic [11:0] codeToMv(input cfs_code_t code);
    codeToMv = `CFS_REF_TOP_MV - 12'(12'(code) * `CFS_REF_STEP_MV);
  endfunction : codeToMv

  // shutdown and start conditions
  assign porClear = !supplyOk || !enableAbove;
  assign runOk = supplyOk && enableAbove && freqSelectShutdownInput
    && (voltageCodeInput != `CFS_CODE_NOLOAD);

  // comparators; undervoltage and at-reference against the live reference
  assign refMv = codeToMv(refCode_ff);
  assign diffPlus = {1'b0, sensedOutputDifference} + `CFS_UV_OFFSET_MV;
  assign cmpRaw[0] = diffPlus < {1'b0, refMv};
  assign cmpRaw[1] = sensedOutputDifference >= `CFS_OV_MV;
  assign cmpRaw[2] = meanChannelCurrent > `CFS_OC_UA;
  assign cmpRaw[3] = sensedOutputDifference <= refMv;

  // metastability guard; results lag the pins by two cycles
  cfs_sync2 #(.W(4)) uSync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .asyncIn(cmpRaw),
    .syncOut(cmpSync)
  );

  assign uvS = cmpSync[0];
  assign ovS = cmpSync[1];
  assign ocS = cmpSync[2];
  assign atRefS = cmpSync[3];

  // phase-clock divider; period 0 behaves as 1
  assign divLast = (divPeriod_ff == 16'h0000) ? 16'h0000 : divPeriod_ff - 16'h0001;
  assign phaseTick = divCnt_ff >= divLast;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      divCnt_ff <= 16'h0000;
    end else begin
      divCnt_ff <= phaseTick ? 16'h0000 : divCnt_ff + 16'h0001;
    end
  end

  // reference tracking of the voltage code
  assign refMoving = refCode_ff != targetCode_ff;
  assign codeStable = voltageCodeInput == codeSeen_ff;

  // code must hold across two phase ticks before it counts; steps every second tick
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      codeSeen_ff <= `CFS_CODE_NOLOAD;
      targetCode_ff <= `CFS_CODE_NOLOAD;
      refCode_ff <= `CFS_CODE_NOLOAD;
      stepPhase_ff <= 1'b0;
    end else if (state_ff == CFS_OFF) begin
      codeSeen_ff <= voltageCodeInput;
      targetCode_ff <= voltageCodeInput;
      refCode_ff <= voltageCodeInput;
      stepPhase_ff <= 1'b0;
    end else if (phaseTick) begin
      codeSeen_ff <= voltageCodeInput;
      if (codeStable && voltageCodeInput != targetCode_ff) begin
        targetCode_ff <= voltageCodeInput;
      end
      stepPhase_ff <= refMoving ? !stepPhase_ff : 1'b0;
      if (refMoving && stepPhase_ff) begin
        refCode_ff <= (refCode_ff < targetCode_ff) ? refCode_ff + 5'h01
          : refCode_ff - 5'h01;
      end
    end
  end

  // fault qualifiers
  assign active = (state_ff == CFS_SOFT) || (state_ff == CFS_RUN);
  assign ocTrip = ocS && !refMoving && active;
  assign tickWrap = phaseTick && (tickCnt_ff == `CFS_TICK_LAST);
  assign retryFull = retryCnt_ff == `CFS_RETRY_LAST;

  // sequencer
  always_comb begin
    nxtState = state_ff;
    nxtTickCnt = phaseTick ? tickCnt_ff + 11'h001 : tickCnt_ff;
    unique case (state_ff)
      CFS_OFF: begin
        nxtTickCnt = 11'h000;
        if (runOk && !ovLatched_ff && !ocLatched_ff) begin
          nxtState = CFS_SOFT;
        end
      end
      CFS_SOFT: begin
        if (ocTrip) begin
          nxtState = CFS_WAIT;
          nxtTickCnt = 11'h000;
        end else if (tickWrap) begin
          nxtState = CFS_RUN;
        end
      end
      CFS_RUN: begin
        nxtTickCnt = 11'h000;
        if (ocTrip) begin
          nxtState = CFS_WAIT;
        end
      end
      CFS_WAIT: begin
        if (tickWrap) begin
          nxtState = CFS_SOFT;
        end
      end
    endcase
    // shutdown, overvoltage and latch-off override everything
    if (!runOk || ovLatched_ff || ovS || (ocTrip && retryFull)) begin
      nxtState = CFS_OFF;
      nxtTickCnt = 11'h000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_ff <= CFS_OFF;
      tickCnt_ff <= 11'h000;
    end else begin
      state_ff <= nxtState;
      tickCnt_ff <= nxtTickCnt;
    end
  end

  // fault latches; enable or supply loss clears them without the clock
  always_ff @(posedge ref_clk or posedge porClear) begin
    if (porClear) begin
      ovLatched_ff <= 1'b0;
      ocLatched_ff <= 1'b0;
      retryCnt_ff <= 3'h0;
      ovClamp_ff <= 1'b0;
    end else if (!nrst) begin
      ovLatched_ff <= 1'b0;
      ocLatched_ff <= 1'b0;
      retryCnt_ff <= 3'h0;
      ovClamp_ff <= 1'b0;
    end else begin
      if (ovS) begin
        ovLatched_ff <= 1'b1;
      end
      if (ovS) begin
        ovClamp_ff <= 1'b1;
      end else if (atRefS) begin
        ovClamp_ff <= 1'b0;
      end
      if (ocTrip && retryFull) begin
        ocLatched_ff <= 1'b1;
      end else if (ocTrip) begin
        retryCnt_ff <= retryCnt_ff + 3'h1;
      end else if (state_ff == CFS_SOFT && tickWrap) begin
        retryCnt_ff <= 3'h0;
      end
    end
  end

  // power-good: faults pull low at once, disable waits for undervoltage
  assign nxtPg = !ovLatched_ff && !ovS && !uvS && !ocTrip && !ocLatched_ff
    && ((runOk && active) || (pg_ff && !runOk));

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pg_ff <= 1'b0;
    end else begin
      pg_ff <= nxtPg;
    end
  end

  // open drain: enable low pulls the pin down, otherwise released high
  assign outputInWindowFlagOut = 1'b0;
  assign outputInWindowFlagOeN = pg_ff;

  // pwm channel modes: clamp low, pass modulator, or float
  assign forceLow = ovClamp_ff;
  assign switching = active && !ovLatched_ff && !ovS;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pwmDrive_ff <= 4'h0;
      pwmOeN_ff <= 4'hf;
    end else if (forceLow) begin
      pwmDrive_ff <= 4'h0;
      pwmOeN_ff <= 4'h0;
    end else if (switching) begin
      pwmDrive_ff <= pwmModulated;
      pwmOeN_ff <= 4'h0;
    end else begin
      pwmDrive_ff <= 4'h0;
      pwmOeN_ff <= 4'hf;
    end
  end

  assign pwmDrive = pwmDrive_ff;
  assign pwmOeN = pwmOeN_ff;
  assign crowbarGateDrive = ovLatched_ff;

  // wishbone decode; answers one cycle after the strobe
  assign wbReq = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  assign selCtrl = wb_adr_i == `CFS_REG_CTRL;
  assign selStatus = wb_adr_i == `CFS_REG_STATUS;
  assign selCount = wb_adr_i == `CFS_REG_COUNT;

  // status word; unused bits read zero
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`CFS_ST_STATE_LSB +: 2] = state_ff;
    statusWord[`CFS_ST_RETRY_LSB +: 3] = retryCnt_ff;
    statusWord[`CFS_ST_OVLATCH] = ovLatched_ff;
    statusWord[`CFS_ST_OCLATCH] = ocLatched_ff;
    statusWord[`CFS_ST_OUTPUT_IN_WINDOW_FLAG] = pg_ff;
    statusWord[`CFS_ST_UV] = uvS;
    statusWord[`CFS_ST_OV] = ovS;
    statusWord[`CFS_ST_OC] = ocS;
    statusWord[`CFS_ST_ATREF] = atRefS;
    statusWord[`CFS_ST_MOVING] = refMoving;
    statusWord[`CFS_ST_CLAMP] = ovClamp_ff;
    statusWord[`CFS_ST_PGPIN] = outputInWindowFlagIn;
    statusWord[`CFS_ST_REF_LSB +: 5] = refCode_ff;
  end

  // read data captured on the request, unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      datOut_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= wbReq;
      if (wbReq) begin
        datOut_ff <= selCtrl ? {16'h0000, divPeriod_ff}
          : selStatus ? statusWord
          : selCount ? {21'h0, tickCnt_ff} : 32'h0000_0000;
      end
    end
  end

  // writes land on the acknowledging edge; byte lanes 0 and 1 only
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      divPeriod_ff <= `CFS_DIV_RESET;
    end else if (wbWrite && selCtrl) begin
      if (wb_sel_i[0]) begin
        divPeriod_ff[7:0] <= wb_dat_i[`CFS_CT_DIV_LSB +: 8];
      end
      if (wb_sel_i[1]) begin
        divPeriod_ff[15:8] <= wb_dat_i[`CFS_CT_DIV_LSB + 8 +: 8];
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = datOut_ff;

  // overvoltage: clamp, then all channels driven low
  sequence s_clampOn;
    ##1 ovClamp_ff;
  endsequence

  sequence s_pwmLow;
    ##1 (pwmOeN == 4'h0 && pwmDrive == 4'h0);
  endsequence

  property p_ovClampLow;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      ovS |-> s_clampOn ##0 s_pwmLow;
  endproperty
  a_ovClampLow: assert property (p_ovClampLow)
    else $error("pwm not clamped low after overvoltage");

  property p_ovPgLow;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      ovS |=> !pg_ff && outputInWindowFlagOeN == 1'b0;
  endproperty
  a_ovPgLow: assert property (p_ovPgLow)
    else $error("power-good not pulled low on overvoltage");

  property p_crowbar;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      ovS |=> crowbarGateDrive [*3];
  endproperty
  a_crowbar: assert property (p_crowbar)
    else $error("crowbar gate not held after overvoltage");

  property p_ovHold;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      ovLatched_ff |=> ##1 (!pg_ff && state_ff == CFS_OFF);
  endproperty
  a_ovHold: assert property (p_ovHold)
    else $error("switching or power-good resumed after overvoltage");

  property p_ocFloat;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      (ocTrip && !ovClamp_ff && !ovS) |=> ##1 (pwmOeN == 4'hf || ovClamp_ff);
  endproperty
  a_ocFloat: assert property (p_ocFloat)
    else $error("pwm not floated after overcurrent");

  property p_waitEnd;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      (state_ff == CFS_WAIT && tickWrap && runOk && !ovS && !ovLatched_ff)
        |=> state_ff == CFS_SOFT;
  endproperty
  a_waitEnd: assert property (p_waitEnd)
    else $error("retry did not start after hiccup wait");

  property p_latchOff;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      (ocTrip && retryCnt_ff == 3'h7) |=> ocLatched_ff ##1 state_ff == CFS_OFF;
  endproperty
  a_latchOff: assert property (p_latchOff)
    else $error("no latch-off on eighth failed attempt");

  property p_ssDone;
    @(posedge ref_clk) disable iff (!nrst || porClear)
      (state_ff == CFS_SOFT && tickWrap && !ocTrip && runOk && !ovS && !ovLatched_ff)
        |=> (state_ff == CFS_RUN && retryCnt_ff == 3'h0);
  endproperty
  a_ssDone: assert property (p_ssDone)
    else $error("soft-start completion did not enter run");

  property p_blank;
    @(posedge ref_clk) disable iff (!nrst)
      (refMoving && state_ff == CFS_RUN && runOk && !ovS && !ovLatched_ff)
        |=> state_ff == CFS_RUN;
  endproperty
  a_blank: assert property (p_blank)
    else $error("overcurrent tripped during reference move");

  property p_stayOff;
    @(posedge ref_clk) disable iff (!nrst)
      (state_ff == CFS_OFF && !runOk && !ovClamp_ff)
        |=> (state_ff == CFS_OFF && pwmOeN == 4'hf);
  endproperty
  a_stayOff: assert property (p_stayOff)
    else $error("left shutdown without start conditions");

  property p_offPg;
    @(posedge ref_clk) disable iff (!nrst)
      (state_ff == CFS_OFF && !pg_ff) |=> !pg_ff && outputInWindowFlagOeN == 1'b0;
  endproperty
  a_offPg: assert property (p_offPg)
    else $error("power-good rose in shutdown");
endmodule : cfs_fault_supervisor

// >>> rtl/cfs_params.svh
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH
// register byte offsets on the wishbone port
`define CFS_REG_CTRL 8'h00
`define CFS_REG_STATUS 8'h04
`define CFS_REG_COUNT 8'h08
// reset value of the phase-clock divider (ref_clk cycles per phase tick)
`define CFS_DIV_RESET 16'h0064
// control register fields
`define CFS_CT_DIV_LSB 0
// status register field positions
`define CFS_ST_STATE_LSB 0
`define CFS_ST_RETRY_LSB 2
`define CFS_ST_OVLATCH 5
`define CFS_ST_OCLATCH 6
`define CFS_ST_OUTPUT_IN_WINDOW_FLAG 7
`define CFS_ST_UV 8
`define CFS_ST_OV 9
`define CFS_ST_OC 10
`define CFS_ST_ATREF 11
`define CFS_ST_MOVING 12
`define CFS_ST_CLAMP 13
`define CFS_ST_PGPIN 14
`define CFS_ST_REF_LSB 16
// timing: both soft-start and hiccup wait span one wrap of an 11-bit count
`define CFS_TICK_LAST 11'h7ff
`define CFS_RETRY_LAST 3'h7
// analog thresholds in mV / uA
`define CFS_UV_OFFSET_MV 13'h015e
`define CFS_OV_MV 12'h898
`define CFS_OC_UA 8'h5a
`define CFS_REF_TOP_MV 12'h60e
`define CFS_REF_STEP_MV 12'h019
`define CFS_CODE_NOLOAD 5'h1f
`endif

// >>> rtl/cfs_pkg.sv
package cfs_pkg;
  typedef enum logic [1:0] {CFS_OFF, CFS_SOFT, CFS_RUN, CFS_WAIT} cfs_state_e;
  typedef logic [4:0] cfs_code_t;
  typedef logic [10:0] cfs_tick_t;
endpackage : cfs_pkg

// >>> rtl/cfs_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for comparator results
module cfs_sync2 #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule : cfs_sync2
